// File: spdif_tx_pkg.sv
`default_nettype none
package spdif_tx_pkg;
  // register indices; byte address is index shifted left by two
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int BYTE_SHIFT = 2;
  localparam logic [IDX_W-1:0] IDX_CTRL3 = 6'h09;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_MASK = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_MODE = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_AUX = 6'h10;
  // bit positions in status and mask
  localparam int XFER_BIT = 0;
  localparam int SLIP_BIT = 1;
  localparam int EVT_W = 2;
  // reset values
  localparam logic [7:0] CTRL3_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [EVT_W-1:0] STATUS_RESET = 2'h0;
  // first bytes loaded from the host in split mode
  localparam int HOST_SPLIT_BYTES = 10;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // buffer source choices
  typedef enum logic [1:0] {
    CU_SRC_NONE = 2'h0,
    CU_SRC_HOST = 2'h1,
    CU_SRC_RX = 2'h2,
    CU_SRC_SPLIT = 2'h3
  } cu_src_t;
  // interrupt trigger modes
  typedef enum logic [1:0] {
    TRIG_RISE = 2'h0,
    TRIG_FALL = 2'h1,
    TRIG_LEVEL = 2'h2,
    TRIG_RSVD = 2'h3
  } trig_mode_t;
  // control register three layout
  typedef struct packed {
    logic [4:0] zero;
    logic v_bit_source_select;
    cu_src_t cu_buffer_source;
  } ctrl3_t;
  // interrupt mode register layout
  typedef struct packed {
    logic [3:0] zero;
    trig_mode_t slip_irq_trigger_mode;
    trig_mode_t xfer_irq_trigger_mode;
  } mode_t;
  // auxiliary control bits
  typedef struct packed {
    logic [4:0] zero;
    logic buffer_xfer_disable;
    logic slip_source_select;
    logic validity_value;
  } aux_t;
endpackage
`default_nettype wire

// File: irq_trigger.sv
`default_nettype none
module irq_trigger (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // trigger selection and event
  input wire spdif_tx_pkg::trig_mode_t mode,
  input wire logic event_in,
  // one cycle per qualifying edge, or every cycle in level mode
  output logic fire
);
  logic prev; // event level one cycle ago

  // remember the previous level for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b0;
    end else begin
      prev <= event_in;
    end
  end

  // select the active trigger state; the reserved code never fires
  always_comb begin
    case (mode)
      spdif_tx_pkg::TRIG_RISE: fire = event_in & ~prev;
      spdif_tx_pkg::TRIG_FALL: fire = ~event_in & prev;
      spdif_tx_pkg::TRIG_LEVEL: fire = event_in;
      default: fire = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// File: spdif_tx_status_irq_regs.sv
// Implementation choice: the AXI4-Lite register port.
`default_nettype none
// Operation
// R1 - field selects user buffer load source
// R2 - split mode: first ten bytes host
// R3 - validity bit from control or receiver
// R4 - transfer done sets flag when enabled
// R5 - transfer flag drives interrupt and summary
// R6 - slip or block start sets slip flag
// R7 - select bit picks slip event source
// R8 - slip flag drives interrupt and summary
// R9 - transfer enable zero masks, one enables
// R10 - status: bit0 transfer, bit1 slip
// R11 - control three: source, validity, zeros
// R12 - mask: transfer bit0, slip bit1
// R13 - slip enable zero masks, one enables
// R14 - per-interrupt trigger mode selection
// R15 - interrupt released when nothing pending
module spdif_tx_status_irq_regs #(
  parameter int BYTE_IDX_W = 5
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [spdif_tx_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [spdif_tx_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // events from the transmitter core
  input wire logic xfer_copy_done,
  input wire logic data_slip,
  input wire logic block_start,
  input wire logic rx_v_bit,
  input wire logic other_irq_pending,
  // user buffer loading
  input wire logic [BYTE_IDX_W-1:0] ua_byte_index,
  output logic [1:0] cu_buffer_source,
  output logic ua_host_load,
  output logic ua_receiver_load,
  // transmitter control
  output logic v_bit_out,
  output logic buffer_xfer_disable,
  // interrupt
  output logic tx_summary_flag,
  output logic irq,
  output logic int_n
);
  ////////////////////////////////////////////////////////////////////////////
  // registers and bus state
  spdif_tx_pkg::ctrl3_t ctrl3; // buffer source and validity select
  spdif_tx_pkg::mode_t mode; // trigger modes
  spdif_tx_pkg::aux_t aux; // validity value, slip source, transfer disable
  logic [7:0] mask; // interrupt enables
  logic [spdif_tx_pkg::EVT_W-1:0] status; // sticky event flags
  logic aw_held; // write address captured
  logic w_held; // write data captured
  logic [spdif_tx_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write; // both halves present, response free
  logic [spdif_tx_pkg::IDX_W-1:0] widx; // decoded write index
  logic xfer_fire; // qualified transfer trigger
  logic slip_fire; // qualified slip trigger
  logic slip_event; // chosen slip source
  logic xfer_set; // transfer flag set this cycle
  logic slip_set; // slip flag set this cycle
  logic [spdif_tx_pkg::EVT_W-1:0] status_clr; // write-one-to-clear bits
  logic tx_pending; // unmasked transmitter flag present

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  // word index of a byte address
  function automatic logic [spdif_tx_pkg::IDX_W-1:0] to_idx(
      input logic [spdif_tx_pkg::ADDR_W-1:0] a);
    to_idx = a[spdif_tx_pkg::ADDR_W-1:spdif_tx_pkg::BYTE_SHIFT];
  endfunction

  // true for a mapped, word-aligned address
  function automatic logic is_mapped(input logic [spdif_tx_pkg::ADDR_W-1:0] a);
    logic [spdif_tx_pkg::IDX_W-1:0] i;
    i = to_idx(a);
    is_mapped = (a[spdif_tx_pkg::BYTE_SHIFT-1:0] == 2'h0) &&
                (i == spdif_tx_pkg::IDX_CTRL3 || i == spdif_tx_pkg::IDX_STATUS ||
                 i == spdif_tx_pkg::IDX_MASK || i == spdif_tx_pkg::IDX_MODE ||
                 i == spdif_tx_pkg::IDX_AUX);
  endfunction

  // true when a user buffer byte comes from the host
  function automatic logic byte_from_host(input spdif_tx_pkg::cu_src_t src,
                                          input logic [BYTE_IDX_W-1:0] bi);
    case (src)
      spdif_tx_pkg::CU_SRC_HOST: byte_from_host = 1'b1;
      spdif_tx_pkg::CU_SRC_SPLIT:
        byte_from_host = (32'(bi) < spdif_tx_pkg::HOST_SPLIT_BYTES);
      default: byte_from_host = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign awready = ~aw_held & ~bvalid;
  assign wready = ~w_held & ~bvalid;
  assign do_write = aw_held & w_held & ~bvalid;
  assign widx = to_idx(awaddr_q);

  // capture write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      awaddr_q <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      awaddr_q <= awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // capture write data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= spdif_tx_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= is_mapped(awaddr_q) ? spdif_tx_pkg::RESP_OKAY : spdif_tx_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers; only lane zero carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl3 <= spdif_tx_pkg::CTRL3_RESET;
    end else if (do_write && wstrb_q[0] && widx == spdif_tx_pkg::IDX_CTRL3 &&
                 is_mapped(awaddr_q)) begin
      ctrl3 <= '{zero: 5'h00, v_bit_source_select: wdata_q[2], // R11
                 cu_buffer_source: spdif_tx_pkg::cu_src_t'(wdata_q[1:0])}; // R1
    end
  end

  // interrupt enables, upper bits held at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= spdif_tx_pkg::MASK_RESET; // R9 R13
    end else if (do_write && wstrb_q[0] && widx == spdif_tx_pkg::IDX_MASK &&
                 is_mapped(awaddr_q)) begin
      mask <= {6'h00, wdata_q[1:0]}; // R12
    end
  end

  // trigger modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= spdif_tx_pkg::MODE_RESET;
    end else if (do_write && wstrb_q[0] && widx == spdif_tx_pkg::IDX_MODE &&
                 is_mapped(awaddr_q)) begin
      mode <= {4'h0, wdata_q[3:0]}; // R14
    end
  end

  // validity value, slip source select, transfer disable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux <= spdif_tx_pkg::AUX_RESET;
    end else if (do_write && wstrb_q[0] && widx == spdif_tx_pkg::IDX_AUX &&
                 is_mapped(awaddr_q)) begin
      aux <= {5'h00, wdata_q[2:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event triggering and sticky flags
  // transfer-done trigger
  irq_trigger u_xfer_trig (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode.xfer_irq_trigger_mode),
    .event_in(xfer_copy_done),
    .fire(xfer_fire)
  );

  assign slip_event = aux.slip_source_select ? block_start : data_slip; // R7

  // slip trigger
  irq_trigger u_slip_trig (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode.slip_irq_trigger_mode),
    .event_in(slip_event),
    .fire(slip_fire)
  );

  // a masked event leaves no trace, so unmasking later raises nothing
  assign xfer_set = xfer_fire & ~aux.buffer_xfer_disable & mask[spdif_tx_pkg::XFER_BIT]; // R4 R9
  assign slip_set = slip_fire & mask[spdif_tx_pkg::SLIP_BIT]; // R6 R13
  assign status_clr = (do_write && wstrb_q[0] && widx == spdif_tx_pkg::IDX_STATUS &&
                       is_mapped(awaddr_q)) ? wdata_q[1:0] : 2'h0;

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= spdif_tx_pkg::STATUS_RESET;
    end else begin
      status <= (status & ~status_clr) | {slip_set, xfer_set}; // R4 R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the transmitter and interrupt
  assign cu_buffer_source = ctrl3.cu_buffer_source; // R1
  assign ua_host_load = byte_from_host(ctrl3.cu_buffer_source, ua_byte_index); // R1 R2
  // receiver loads whatever is not the host's, unless updates are off
  assign ua_receiver_load = (ctrl3.cu_buffer_source != spdif_tx_pkg::CU_SRC_NONE) &&
                            !ua_host_load; // R2
  // zero latency path, so this output is not registered
  assign v_bit_out = ctrl3.v_bit_source_select ? rx_v_bit : aux.validity_value; // R3
  assign buffer_xfer_disable = aux.buffer_xfer_disable;
  assign tx_pending = |(status & mask[spdif_tx_pkg::EVT_W-1:0]); // R5 R8
  assign tx_summary_flag = tx_pending; // R5 R8
  assign irq = tx_pending;
  assign int_n = ~(tx_pending | other_irq_pending); // R15

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle after the address is taken
  assign arready = ~rvalid;

  // read data mux, reserved bits read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= spdif_tx_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= is_mapped(araddr) ? spdif_tx_pkg::RESP_OKAY : spdif_tx_pkg::RESP_SLVERR;
      if (!is_mapped(araddr)) begin
        rdata <= 32'h0000_0000;
      end else begin
        case (to_idx(araddr))
          spdif_tx_pkg::IDX_CTRL3: rdata <= {24'h000000, ctrl3}; // R11
          spdif_tx_pkg::IDX_STATUS: rdata <= {30'h00000000, status}; // R10
          spdif_tx_pkg::IDX_MASK: rdata <= {24'h000000, mask}; // R12
          spdif_tx_pkg::IDX_MODE: rdata <= {24'h000000, mode};
          spdif_tx_pkg::IDX_AUX: rdata <= {24'h000000, aux};
          default: rdata <= 32'h0000_0000;
        endcase
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence ctrl3_wr;
    do_write && wstrb_q[0] && widx == spdif_tx_pkg::IDX_CTRL3 && is_mapped(awaddr_q);
  endsequence

  sequence slip_armed;
    mask[spdif_tx_pkg::SLIP_BIT] && mode.slip_irq_trigger_mode == spdif_tx_pkg::TRIG_LEVEL &&
      (aux.slip_source_select ? block_start : data_slip);
  endsequence

  src_write_a: assert property (ctrl3_wr |=> // R1
      cu_buffer_source == $past(wdata_q[1:0]) && ctrl3.zero == 5'h00)
    else $error("buffer source not stored");
  split_host_a: assert property ( // R2
      cu_buffer_source == spdif_tx_pkg::CU_SRC_SPLIT &&
      32'(ua_byte_index) < spdif_tx_pkg::HOST_SPLIT_BYTES
      |-> ua_host_load && !ua_receiver_load)
    else $error("split low byte not from host");
  split_rx_a: assert property ( // R2
      cu_buffer_source == spdif_tx_pkg::CU_SRC_SPLIT &&
      32'(ua_byte_index) >= spdif_tx_pkg::HOST_SPLIT_BYTES
      |-> !ua_host_load && ua_receiver_load)
    else $error("split high byte not from receiver");
  none_load_a: assert property ( // R1
      cu_buffer_source == spdif_tx_pkg::CU_SRC_NONE |-> !ua_host_load && !ua_receiver_load)
    else $error("buffers loaded while updates off");
  vbit_src_a: assert property ( // R3
      v_bit_out == (ctrl3.v_bit_source_select ? rx_v_bit : aux.validity_value))
    else $error("validity bit source wrong");
  xfer_rise_a: assert property ( // R4
      mode.xfer_irq_trigger_mode == spdif_tx_pkg::TRIG_RISE && $rose(xfer_copy_done) &&
      !aux.buffer_xfer_disable && mask[0] |=> status[0] ##1 status[0] || $past(status_clr[0]))
    else $error("transfer flag not set");
  xfer_block_a: assert property ( // R9
      !status[0] && (aux.buffer_xfer_disable || !mask[0]) |=> !status[0])
    else $error("transfer flag set while blocked");
  slip_set_a: assert property (slip_armed |=> status[1]) // R6
    else $error("slip flag not set");
  slip_sel_a: assert property ( // R7
      !status[1] && mode.slip_irq_trigger_mode == spdif_tx_pkg::TRIG_LEVEL &&
      (aux.slip_source_select ? !block_start : !data_slip) |=> !status[1])
    else $error("unselected slip source set flag");
  slip_mask_a: assert property (!status[1] && !mask[1] |=> !status[1]) // R13
    else $error("masked slip set flag");
  irq_drive_a: assert property ( // R5
      (status[0] && mask[0]) || (status[1] && mask[1]) |-> !int_n && tx_summary_flag && irq)
    else $error("interrupt not asserted");
  irq_release_a: assert property ( // R15
      !(status[0] && mask[0]) && !(status[1] && mask[1]) && !other_irq_pending |-> int_n)
    else $error("interrupt held without source");
  slip_irq_a: assert property ($rose(status[1]) && mask[1] |-> !int_n) // R8
    else $error("slip flag did not interrupt");
  status_rd_a: assert property ( // R10
      arvalid && arready && is_mapped(araddr) && to_idx(araddr) == spdif_tx_pkg::IDX_STATUS |=>
      rvalid && rdata[31:2] == 30'h0 && rdata[1:0] == $past(status))
    else $error("status read wrong");
  mask_wr_a: assert property ( // R12
      do_write && wstrb_q[0] && widx == spdif_tx_pkg::IDX_MASK && is_mapped(awaddr_q) |=>
      mask[7:2] == 6'h00 && mask[1:0] == $past(wdata_q[1:0]))
    else $error("mask layout wrong");
  rsvd_mode_a: assert property ( // R14
      mode.xfer_irq_trigger_mode == spdif_tx_pkg::TRIG_RSVD && !status[0] |=> !status[0])
    else $error("reserved mode triggered");
endmodule
`default_nettype wire

// File: spdif_tx_status_irq_regs_notes_end.sv
`default_nettype none
`default_nettype wire

// File: tx_core_model.sv
`default_nettype none
////////////////////////////////////////////////////////////////
// stand-in for the transmitter core on the block's far side
module tx_core_model (
  // clock
  input wire logic aclk,
  // events and data toward the block
  output logic xfer_copy_done,
  output logic data_slip,
  output logic block_start,
  output logic rx_v_bit,
  output logic [4:0] ua_byte_index
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet at time zero
  initial begin
    xfer_copy_done = 1'b0;
    data_slip = 1'b0;
    block_start = 1'b0;
    rx_v_bit = 1'b0;
    ua_byte_index = 5'h00;
  end
  // receiver validity flips every cycle, so a stale select cannot pass
  always @(posedge aclk) begin
    rx_v_bit <= ~rx_v_bit;
  end
  // event levels; called just after a rising edge
  task automatic set_ev(input logic x, input logic s, input logic b);
    xfer_copy_done <= x;
    data_slip <= s;
    block_start <= b;
  endtask
  // byte being loaded into the user buffer
  task automatic set_idx(input logic [4:0] i);
    ua_byte_index <= i;
  endtask
endmodule
`default_nettype wire

// File: spdif_tx_status_irq_regs_test.sv
`default_nettype none
module spdif_tx_status_irq_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset, bus masters' signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic other_irq_pending = 1'b0;
  // design outputs
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, cu_buffer_source;
  logic [31:0] rdata;
  logic ua_host_load, ua_receiver_load, v_bit_out, buffer_xfer_disable;
  logic tx_summary_flag, irq, int_n;
  // far side nets
  logic xfer_copy_done, data_slip, block_start, rx_v_bit;
  logic [4:0] ua_byte_index, idx;
  int mismatches = 0, checked = 0;
  integer seed;

  always #4 aclk = ~aclk;

  tx_core_model core (.aclk(aclk), .xfer_copy_done(xfer_copy_done), .data_slip(data_slip),
    .block_start(block_start), .rx_v_bit(rx_v_bit), .ua_byte_index(ua_byte_index));

  spdif_tx_status_irq_regs #(.BYTE_IDX_W(5)) uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .xfer_copy_done(xfer_copy_done), .data_slip(data_slip), .block_start(block_start),
    .rx_v_bit(rx_v_bit), .other_irq_pending(other_irq_pending),
    .ua_byte_index(ua_byte_index), .cu_buffer_source(cu_buffer_source),
    .ua_host_load(ua_host_load), .ua_receiver_load(ua_receiver_load),
    .v_bit_out(v_bit_out), .buffer_xfer_disable(buffer_xfer_disable),
    .tx_summary_flag(tx_summary_flag), .irq(irq), .int_n(int_n));

  ////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // verdict, then stop
  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // expected {host, receiver} load strobes for a source and byte index
  function automatic logic [1:0] ld_exp(input logic [1:0] s, input logic [4:0] i);
    case (s)
      2'h1: return 2'h2;
      2'h2: return 2'h1;
      2'h3: return (i < 5'h0A) ? 2'h2 : 2'h1;
      default: return 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk({30'h0, bresp}, {30'h0, er});
        n = 99;
      end
    end
    bready <= 1'b0;
    if (n != 99) chk(32'h0, 32'h1);
    // one spare edge so bready is never assigned twice in one step
    @(posedge aclk);
  endtask
  // read and compare data and response
  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        chk(rdata, {24'h0, ed});
        chk({30'h0, rresp}, {30'h0, er});
        n = 99;
      end
    end
    rready <= 1'b0;
    if (n != 99) chk(32'h0, 32'h1);
    @(posedge aclk);
  endtask
  // one-cycle event pulse, then let the flag settle
  task automatic ev(input logic x, input logic s, input logic b);
    core.set_ev(x, s, b);
    @(posedge aclk);
    core.set_ev(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge aclk);
  endtask
  // interrupt pins as {irq, summary, int_n}, sampled mid-cycle
  task automatic pins(input logic [2:0] e);
    @(negedge aclk);
    chk({29'h0, irq, tx_summary_flag, int_n}, {29'h0, e});
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////
  // watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    results;
  end

  initial begin
    seed = 32'h8620;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h24, 8'h00, 2'h0);
    rd(8'h28, 8'h00, 2'h0);
    rd(8'h2C, 8'h00, 2'h0);
    pins(3'h1);
    // reserved bits read zero
    wr(8'h24, 8'hFF, 2'h0);
    rd(8'h24, 8'h07, 2'h0);
    wr(8'h2C, 8'hFF, 2'h0);
    rd(8'h2C, 8'h03, 2'h0);
    wr(8'h14, 8'hFF, 2'h0 | 2'h2);
    rd(8'h14, 8'h00, 2'h2);
    rd(8'h25, 8'h00, 2'h2);
    // every buffer source, split boundary bytes 9 and 10 first
    for (int s = 0; s < 4; s++) begin
      wr(8'h24, 8'(s), 2'h0);
      for (int k = 0; k < 6; k++) begin
        idx = (k == 0) ? 5'h09 : (k == 1) ? 5'h0A : 5'($random(seed));
        core.set_idx(idx);
        @(posedge aclk);
        @(negedge aclk);
        chk({28'h0, cu_buffer_source, ua_host_load, ua_receiver_load},
          {28'h0, 2'(s), ld_exp(2'(s), idx)});
        @(posedge aclk);
      end
    end
    // validity source: register value or receiver, no delay
    for (int c = 0; c < 4; c++) begin
      wr(8'h40, 8'(c & 1), 2'h0);
      wr(8'h24, 8'((c >> 1) << 2), 2'h0);
      repeat (3) begin
        @(negedge aclk);
        chk({31'h0, v_bit_out}, {31'h0, (c > 1) ? rx_v_bit : c[0]});
        @(posedge aclk);
      end
    end
    // transfer event: masked, disabled, then flagged and cleared
    wr(8'h40, 8'h00, 2'h0);
    wr(8'h2C, 8'h00, 2'h0);
    ev(1'b1, 1'b0, 1'b0);
    rd(8'h28, 8'h00, 2'h0);
    wr(8'h2C, 8'h01, 2'h0);
    wr(8'h40, 8'h04, 2'h0);
    chk({31'h0, buffer_xfer_disable}, 32'h1);
    ev(1'b1, 1'b0, 1'b0);
    rd(8'h28, 8'h00, 2'h0);
    wr(8'h40, 8'h00, 2'h0);
    ev(1'b1, 1'b0, 1'b0);
    rd(8'h28, 8'h01, 2'h0);
    pins(3'h6);
    wr(8'h28, 8'h01, 2'h0);
    rd(8'h28, 8'h00, 2'h0);
    pins(3'h1);
    // slip source select and slip mask
    wr(8'h2C, 8'h03, 2'h0);
    ev(1'b0, 1'b0, 1'b1);
    rd(8'h28, 8'h00, 2'h0);
    ev(1'b0, 1'b1, 1'b0);
    rd(8'h28, 8'h02, 2'h0);
    pins(3'h6);
    wr(8'h28, 8'h02, 2'h0);
    wr(8'h40, 8'h02, 2'h0);
    ev(1'b0, 1'b1, 1'b0);
    rd(8'h28, 8'h00, 2'h0);
    ev(1'b1, 1'b0, 1'b1);
    rd(8'h28, 8'h03, 2'h0);
    wr(8'h28, 8'h03, 2'h0);
    wr(8'h2C, 8'h01, 2'h0);
    ev(1'b0, 1'b0, 1'b1);
    rd(8'h28, 8'h00, 2'h0);
    // trigger modes on both events: held high, then released
    wr(8'h2C, 8'h03, 2'h0);
    for (int e = 0; e < 2; e++) begin
      for (int m = 0; m < 4; m++) begin
        wr(8'h30, 8'(m << (2 * e)), 2'h0);
        wr(8'h28, 8'h03, 2'h0);
        core.set_ev(e == 0, e == 1, e == 1);
        repeat (3) @(posedge aclk);
        rd(8'h28, 8'(((m == 0 || m == 2) ? 1 : 0) << e), 2'h0);
        core.set_ev(1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge aclk);
        rd(8'h28, 8'(((m != 3) ? 1 : 0) << e), 2'h0);
        wr(8'h28, 8'h03, 2'h0);
      end
    end
    // another source alone holds the shared pin low
    other_irq_pending <= 1'b1;
    @(posedge aclk);
    pins(3'h0);
    other_irq_pending <= 1'b0;
    @(posedge aclk);
    pins(3'h1);
    results;
  end
endmodule
`default_nettype wire
